// ===== include/mft_pkg.sv
// constants, modes and state carriers of the multi-function timer control block
package mft_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] MFT_OFS_FLAG_ENABLE = 8'h00;
    localparam logic [7:0] MFT_OFS_MODE_SETUP = 8'h04;
    localparam logic [7:0] MFT_OFS_FIRST_CMP = 8'h08;
    localparam logic [7:0] MFT_OFS_SECOND_CMP = 8'h0C;
    localparam logic [7:0] MFT_OFS_CAPTURE = 8'h10;
    localparam logic [7:0] MFT_OFS_COUNTER = 8'h14;
    localparam logic [7:0] MFT_OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] MFT_OFS_IRQ_MASK = 8'h1C;

    // ------------------------------------------------------------
    // flag and enable register fields
    // ------------------------------------------------------------
    localparam int MFT_A_CAP2_FLAG = 7;
    localparam int MFT_A_CAP1_FLAG = 6;
    localparam int MFT_A_CAP_IE = 5;
    localparam int MFT_A_MATCH2_FLAG = 4;
    localparam int MFT_A_MATCH1_FLAG = 3;
    localparam int MFT_A_MATCH_IE = 2;
    localparam int MFT_A_WRAP_FLAG = 1;
    localparam int MFT_A_WRAP_IE = 0;
    localparam logic [7:0] MFT_A_STICKY = 8'hDA;

    // ------------------------------------------------------------
    // mode setup register fields
    // ------------------------------------------------------------
    localparam int MFT_B_RT_WRAP_FLAG = 7;
    localparam int MFT_B_CAP_EDGE = 6;
    localparam int MFT_B_EVENT_EDGE = 5;
    localparam int MFT_B_DIV_LSB = 2;
    localparam int MFT_B_DIV_MSB = 4;
    localparam logic [7:0] MFT_B_STICKY = 8'h80;

    // ------------------------------------------------------------
    // interrupt status bit positions
    // ------------------------------------------------------------
    localparam int MFT_ST_WRAP = 0;
    localparam int MFT_ST_MATCH1 = 1;
    localparam int MFT_ST_MATCH2 = 2;
    localparam int MFT_ST_CAP1 = 3;
    localparam int MFT_ST_CAP2 = 4;
    localparam int MFT_ST_RT_WRAP = 5;
    localparam int MFT_ST_W = 6;

    // ------------------------------------------------------------
    // values after reset and counter limits
    // ------------------------------------------------------------
    localparam logic [7:0] MFT_RST_REG8 = 8'h00;
    localparam logic [15:0] MFT_RST_REG16 = 16'h0000;
    localparam logic [15:0] MFT_CNT_MAX = 16'hFFFF;
    localparam logic [6:0] MFT_RST_PRESCALE = 7'h00;
    localparam int MFT_PINS = 3;
    localparam int MFT_PIN_CAP1 = 0;
    localparam int MFT_PIN_CAP2 = 1;
    localparam int MFT_PIN_EVENT = 2;

    typedef enum logic [1:0] {
        MFT_MODE_SW_TIMER = 2'h0,
        MFT_MODE_PWM = 2'h1,
        MFT_MODE_CAP_CMP = 2'h2,
        MFT_MODE_EXT_EVENT = 2'h3
    } mft_mode_t;

    // ------------------------------------------------------------
    // state carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [MFT_PINS-1:0] stg1;
        logic [MFT_PINS-1:0] stg2;
        logic [MFT_PINS-1:0] stg3;
        logic [MFT_PINS-1:0] lvl;
        logic [MFT_PINS-1:0] prv;
    } mft_sync_state_t;

    typedef struct packed {
        logic [7:0] flag_enable;
        logic [7:0] mode_setup;
        logic [15:0] first_cmp;
        logic [15:0] second_cmp;
        logic [15:0] capture;
        logic [15:0] count;
        logic second_active;
        logic out_lvl;
        logic [MFT_ST_W-1:0] status;
        logic [MFT_ST_W-1:0] mask;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } mft_state_t;

endpackage : mft_pkg

// ===== verilog/mft_pin_sync.sv
// three-stage synchronisers with edge pulses for the timer input pins
`timescale 1ns/1ps
`default_nettype none
module mft_pin_sync import mft_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [MFT_PINS-1:0] pins_in,
    output logic [MFT_PINS-1:0] rise,
    output logic [MFT_PINS-1:0] fall
);

    mft_sync_state_t q;
    mft_sync_state_t d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // stage 1 feeds stage 2 only; the level moves once 2 and 3 agree
    always_comb begin
        d = q;
        d.stg1 = pins_in;
        d.stg2 = q.stg1;
        d.stg3 = q.stg2;
        d.prv = q.lvl;
        for (int i = 0; i < MFT_PINS; i++) begin
            if (q.stg2[i] == q.stg3[i]) begin
                d.lvl[i] = q.stg3[i];
            end
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // one-cycle pulses, both terms from flops
    assign rise = q.lvl & ~q.prv;
    assign fall = ~q.lvl & q.prv;

endmodule : mft_pin_sync
`default_nettype wire

// ===== verilog/mft_prescaler.sv
// power-of-two divider making the timer tick from the system clock
`timescale 1ns/1ps
`default_nettype none
module mft_prescaler import mft_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [2:0] div_sel,
    output logic tick
);

    logic [6:0] q;
    logic [6:0] d;
    logic [6:0] low_mask;

    // ------------------------------------------------------------
    // free-running count; tick when the selected low bits are all ones
    // ------------------------------------------------------------
    // a change of divider may give one short first period, no more
    always_comb begin
        d = q + 7'h01;
        low_mask = 7'(8'hFF >> (4'h8 - {1'b0, div_sel}));
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= MFT_RST_PRESCALE;
        end else begin
            q <= d;
        end
    end

    assign tick = ((q & low_mask) == low_mask); // R12

endmodule : mft_prescaler
`default_nettype wire

// ===== verilog/mft_timer_ctrl.sv
// control, status and counter logic of the first multi-function timer
//
// Summary of operation
// R1 - second capture input sets sticky flag bit 7
// R2 - first capture input sets sticky flag bit 6
// R3 - bit 5 enables capture interrupts
// R4 - match on second compare sets flag 4
// R5 - match on first compare sets flag 3
// R6 - bit 2 enables match interrupts
// R7 - counter wrap FFFF to 0000 sets flag 1
// R8 - bit 0 enables wrap interrupts
// R9 - real-time counter wrap sets mode bit 7
// R10 - mode bit 6 picks capture edge
// R11 - mode bit 5 picks event clock edge
// R12 - mode bits 4..2 divide clock by 2^n
// R13 - mode bits 1..0 pick operating mode
// R14 - counter resets to zero, counts up per tick
// R15 - pwm alternates compares, restarts, toggles output
// R16 - capture mode free runs, captures, toggles output
// R17 - event mode counts external edges like pwm
// R18 - timer request while any enabled flag set; capture flags count only in capture/compare mode
// R19 - writing zero clears flag; set wins
`timescale 1ns/1ps
`default_nettype none
module mft_timer_ctrl import mft_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic first_capture_pin,
    input wire logic second_capture_pin,
    input wire logic event_clock_pin,
    input wire logic rt_counter_wrap,
    output logic compare_output_pin,
    output logic timer_irq,
    output logic irq
);

    mft_state_t q;
    mft_state_t d;
    logic [MFT_PINS-1:0] pin_rise;
    logic [MFT_PINS-1:0] pin_fall;
    logic pre_tick;
    logic tick;
    logic cap1_edge;
    logic cap2_edge;
    logic event_edge;
    logic bus_take;
    mft_mode_t mode;

    // ------------------------------------------------------------
    // pin synchronisers and clock divider
    // ------------------------------------------------------------
    mft_pin_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pins_in({event_clock_pin, second_capture_pin, first_capture_pin}),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    mft_prescaler u_prescale (
        .hclk(hclk),
        .hresetn(hresetn),
        .div_sel(q.mode_setup[MFT_B_DIV_MSB:MFT_B_DIV_LSB]), // R12
        .tick(pre_tick)
    );

    // ------------------------------------------------------------
    // edge selection and tick source
    // ------------------------------------------------------------
    // one polarity bit serves both capture inputs
    assign cap1_edge = q.mode_setup[MFT_B_CAP_EDGE] ? pin_rise[MFT_PIN_CAP1]
                                                    : pin_fall[MFT_PIN_CAP1]; // R10
    assign cap2_edge = q.mode_setup[MFT_B_CAP_EDGE] ? pin_rise[MFT_PIN_CAP2]
                                                    : pin_fall[MFT_PIN_CAP2]; // R10
    assign event_edge = q.mode_setup[MFT_B_EVENT_EDGE] ? pin_rise[MFT_PIN_EVENT]
                                                       : pin_fall[MFT_PIN_EVENT]; // R11
    assign mode = mft_mode_t'(q.mode_setup[1:0]); // R13
    assign tick = (mode == MFT_MODE_EXT_EVENT) ? event_edge : pre_tick; // R17

    // address phase accepted when selected, non-idle and bus ready
    assign bus_take = hsel & hready & htrans[1];

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    function automatic logic [31:0] read_word(input mft_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            MFT_OFS_FLAG_ENABLE: r = {24'h00_0000, s.flag_enable};
            MFT_OFS_MODE_SETUP: r = {24'h00_0000, s.mode_setup};
            MFT_OFS_FIRST_CMP: r = {16'h0000, s.first_cmp};
            MFT_OFS_SECOND_CMP: r = {16'h0000, s.second_cmp};
            MFT_OFS_CAPTURE: r = {16'h0000, s.capture};
            MFT_OFS_COUNTER: r = {16'h0000, s.count};
            MFT_OFS_IRQ_STATUS: r = {26'h000_0000, s.status};
            MFT_OFS_IRQ_MASK: r = {26'h000_0000, s.mask};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_word

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // software effects first, hardware events last so a set always wins
    always_comb begin : next_state
        logic ev_wrap;
        logic ev_m1;
        logic ev_m2;
        logic ev_c1;
        logic ev_c2;
        logic [15:0] active_cmp;
        ev_wrap = 1'b0;
        ev_m1 = 1'b0;
        ev_m2 = 1'b0;
        ev_c1 = 1'b0;
        ev_c2 = 1'b0;
        active_cmp = q.second_active ? q.second_cmp : q.first_cmp;
        d = q;

        // address phase: latch writes, fetch read data into a flop
        d.wr_pend = bus_take & hwrite;
        d.wr_addr = haddr[7:0];
        if (bus_take && !hwrite) begin
            d.rdata = read_word(q, haddr[7:0]);
            if (haddr[7:0] == MFT_OFS_IRQ_STATUS) begin
                d.status = '0; // read clears
            end
        end

        // data phase of a write
        if (q.wr_pend) begin
            unique case (q.wr_addr)
                MFT_OFS_FLAG_ENABLE: begin
                    // sticky bits only lose a one, never gain it
                    d.flag_enable = (hwdata[7:0] & ~MFT_A_STICKY)
                                  | (hwdata[7:0] & q.flag_enable & MFT_A_STICKY); // R19
                end
                MFT_OFS_MODE_SETUP: begin
                    d.mode_setup = (hwdata[7:0] & ~MFT_B_STICKY)
                                 | (hwdata[7:0] & q.mode_setup & MFT_B_STICKY); // R19
                    d.second_active = 1'b0; // a new mode starts on the first compare
                end
                MFT_OFS_FIRST_CMP: d.first_cmp = hwdata[15:0];
                MFT_OFS_SECOND_CMP: d.second_cmp = hwdata[15:0];
                MFT_OFS_IRQ_MASK: d.mask = hwdata[MFT_ST_W-1:0];
                default: begin
                    // read-only or unmapped: write ignored
                end
            endcase
        end

        // counter
        if (tick) begin
            if (mode == MFT_MODE_CAP_CMP) begin
                d.count = q.count + 16'h0001; // R16
                ev_wrap = (q.count == MFT_CNT_MAX); // R7
                if (q.count == q.first_cmp) begin
                    ev_m1 = 1'b1; // R5
                    d.out_lvl = ~q.out_lvl; // R16
                end
            end else if (q.count == active_cmp) begin
                // restart and swap compare source
                d.count = MFT_RST_REG16; // R15
                d.second_active = ~q.second_active; // R15
                ev_m1 = ~q.second_active; // R5
                ev_m2 = q.second_active; // R4
                if (mode != MFT_MODE_SW_TIMER) begin
                    d.out_lvl = ~q.out_lvl; // R15
                end
            end else begin
                d.count = q.count + 16'h0001; // R14
                ev_wrap = (q.count == MFT_CNT_MAX); // R7
            end
        end

        // captures only act in capture/compare mode
        if (mode == MFT_MODE_CAP_CMP) begin
            ev_c1 = cap1_edge;
            ev_c2 = cap2_edge;
            if (cap1_edge) begin
                d.capture = q.count; // R16
            end
            if (cap2_edge) begin
                d.second_cmp = q.count; // R16
            end
        end

        // sticky flags, set over any same-cycle clear
        if (ev_c2) begin
            d.flag_enable[MFT_A_CAP2_FLAG] = 1'b1; // R1
        end
        if (ev_c1) begin
            d.flag_enable[MFT_A_CAP1_FLAG] = 1'b1; // R2
        end
        if (ev_m2) begin
            d.flag_enable[MFT_A_MATCH2_FLAG] = 1'b1; // R4
        end
        if (ev_m1) begin
            d.flag_enable[MFT_A_MATCH1_FLAG] = 1'b1; // R5
        end
        if (ev_wrap) begin
            d.flag_enable[MFT_A_WRAP_FLAG] = 1'b1; // R7
        end
        if (rt_counter_wrap) begin
            d.mode_setup[MFT_B_RT_WRAP_FLAG] = 1'b1; // R9
        end

        // event status, also set over a clearing read
        if (ev_wrap) begin
            d.status[MFT_ST_WRAP] = 1'b1;
        end
        if (ev_m1) begin
            d.status[MFT_ST_MATCH1] = 1'b1;
        end
        if (ev_m2) begin
            d.status[MFT_ST_MATCH2] = 1'b1;
        end
        if (ev_c1) begin
            d.status[MFT_ST_CAP1] = 1'b1;
        end
        if (ev_c2) begin
            d.status[MFT_ST_CAP2] = 1'b1;
        end
        if (rt_counter_wrap) begin
            d.status[MFT_ST_RT_WRAP] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0; // R14
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign compare_output_pin = q.out_lvl;

    // capture requests only count in capture/compare mode
    assign timer_irq = ((q.flag_enable[MFT_A_CAP2_FLAG] | q.flag_enable[MFT_A_CAP1_FLAG])
                        & q.flag_enable[MFT_A_CAP_IE] & (mode == MFT_MODE_CAP_CMP)) // R3
                     | ((q.flag_enable[MFT_A_MATCH2_FLAG] | q.flag_enable[MFT_A_MATCH1_FLAG])
                        & q.flag_enable[MFT_A_MATCH_IE]) // R6
                     | (q.flag_enable[MFT_A_WRAP_FLAG] & q.flag_enable[MFT_A_WRAP_IE]); // R8 R18

    assign irq = |(q.status & q.mask);

endmodule : mft_timer_ctrl
`default_nettype wire

// ===== bench/mft_pin_model.sv
// pin-side model: capture inputs and external event clock
`timescale 1ns/1ps
`default_nettype none
module mft_pin_model (
    input wire logic hclk,
    output var logic cap1,
    output var logic cap2,
    output var logic evt
);
    // pins idle low; each level is held several clocks so the sync stages see it
    initial begin
        cap1 = 1'b0;
        cap2 = 1'b0;
        evt = 1'b0;
    end

    // move one capture pin, then hold it
    task automatic set_pin(input int i, input logic v, input int hold);
        @(posedge hclk);
        if (i == 0) cap1 <= v;
        else cap2 <= v;
        repeat (hold) @(posedge hclk);
    endtask : set_pin

    // k full event pulses; hold sets the pace, slow or prompt
    task automatic burst(input int k, input int hold);
        for (int j = 0; j < 2 * k; j++) begin
            @(posedge hclk);
            evt <= ~evt;
            repeat (hold) @(posedge hclk);
        end
    endtask : burst
endmodule : mft_pin_model
`default_nettype wire

// ===== bench/mft_timer_ctrl_checker.sv
// assertion checker bound to the timer control block ports
`timescale 1ns/1ps
`default_nettype none
module mft_timer_ctrl_checker import mft_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic first_capture_pin,
    input wire logic second_capture_pin,
    input wire logic event_clock_pin,
    input wire logic rt_counter_wrap,
    input wire logic compare_output_pin,
    input wire logic timer_irq,
    input wire logic irq
);
    logic wr_q;
    logic [7:0] ad_q;
    logic [2:0] en_q;
    logic [1:0] md_q;
    logic eg_q;
    logic [5:0] mk_q;

    // shadow of the enables, mode, edge and mask, taken from bus writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            ad_q <= 8'h00;
            en_q <= 3'h0;
            md_q <= 2'h0;
            eg_q <= 1'b0;
            mk_q <= 6'h00;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            ad_q <= haddr[7:0];
            if (wr_q && ad_q == MFT_OFS_FLAG_ENABLE)
                en_q <= {hwdata[MFT_A_CAP_IE], hwdata[MFT_A_MATCH_IE], hwdata[MFT_A_WRAP_IE]};
            if (wr_q && ad_q == MFT_OFS_MODE_SETUP)
                md_q <= hwdata[1:0];
            if (wr_q && ad_q == MFT_OFS_MODE_SETUP)
                eg_q <= hwdata[MFT_B_CAP_EDGE];
            if (wr_q && ad_q == MFT_OFS_IRQ_MASK)
                mk_q <= hwdata[5:0];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // sync stages take a few clocks, so capture requests get a window
    sequence s_cap1;
        $rose(first_capture_pin) && eg_q && md_q == MFT_MODE_CAP_CMP && en_q[2];
    endsequence
    sequence s_cap2;
        $fell(second_capture_pin) && !eg_q && md_q == MFT_MODE_CAP_CMP && en_q[2];
    endsequence
    sequence s_ev_quiet;
        ($stable(event_clock_pin) && md_q == MFT_MODE_EXT_EVENT) [*8];
    endsequence
    property p_cap1;
        s_cap1 |-> ##[1:9] timer_irq;
    endproperty
    property p_cap2;
        s_cap2 |-> ##[1:9] timer_irq;
    endproperty
    property p_ev_hold;
        s_ev_quiet |-> $stable(compare_output_pin);
    endproperty
    property p_sw_hold;
        md_q == MFT_MODE_SW_TIMER && $past(md_q) == MFT_MODE_SW_TIMER
            |-> $stable(compare_output_pin);
    endproperty
    property p_rt;
        rt_counter_wrap && mk_q[MFT_ST_RT_WRAP] |=> irq;
    endproperty
    property p_mask;
        mk_q == 6'h00 |-> !irq;
    endproperty
    property p_no_en;
        en_q == 3'h0 |-> !timer_irq;
    endproperty
    property p_cap_mode;
        en_q == 3'h4 && md_q != MFT_MODE_CAP_CMP |-> !timer_irq;
    endproperty
    a_cap1: assert property (p_cap1)
        else $error("first capture raised no request");
    a_cap2: assert property (p_cap2)
        else $error("second capture raised no request");
    a_ev_hold: assert property (p_ev_hold)
        else $error("output moved without event edge");
    a_sw_hold: assert property (p_sw_hold)
        else $error("output moved in software timer mode");
    a_rt: assert property (p_rt)
        else $error("rt wrap gave no interrupt");
    a_mask: assert property (p_mask)
        else $error("interrupt with mask clear");
    a_no_en: assert property (p_no_en)
        else $error("timer request with enables clear");
    a_cap_mode: assert property (p_cap_mode)
        else $error("capture request outside capture mode");
endmodule : mft_timer_ctrl_checker
bind mft_timer_ctrl mft_timer_ctrl_checker u_chk (.*);
`default_nettype wire

// ===== bench/mft_timer_ctrl_test.sv
// self-checking testbench of the timer control block
`timescale 1ns/1ps
`default_nettype none
module mft_timer_ctrl_test import mft_pkg::*; ;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic rt_wrap = 1'b0;
    logic hreadyout, hresp, out_pin, timer_irq, irq, cap1, cap2, evt;
    logic [31:0] hrdata;
    int errors = 0;
    int n_compared = 0;

    always #5 hclk = ~hclk;

    mft_timer_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .first_capture_pin(cap1),
        .second_capture_pin(cap2), .event_clock_pin(evt), .rt_counter_wrap(rt_wrap),
        .compare_output_pin(out_pin), .timer_irq(timer_irq), .irq(irq));
    mft_pin_model pins (.hclk(hclk), .cap1(cap1), .cap2(cap2), .evt(evt));

    // ----
    // bus cycles and comparison
    // ----
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0, r);
    endtask : rd
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // clocks until the compare output next changes
    task automatic tog(output int c);
        logic p;
        p = out_pin;
        c = 0;
        do begin
            @(posedge hclk);
            c++;
        end while (out_pin === p && c < 70000);
    endtask : tog
    // whole ticks in the span between two counter reads, k idle clocks apart
    function automatic logic [15:0] ticks(input int k, input int n);
        return 16'((k + 3) >> n);
    endfunction : ticks
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out

    // hang guard, well beyond the longest wrap wait
    initial begin
        repeat (100000) @(posedge hclk);
        errors++;
        close_out();
    end

    // ----
    // tests
    // ----
    initial begin : main
        logic [15:0] tb [9];
        logic [31:0] r, c0, c1, c2;
        int a, b, k, d1, d2;
        // address and value after reset; zero compares match on every tick
        // flags are read second, once both compares have had their first match
        tb = '{16'h0400, 16'h0018, 16'h0800, 16'h0C00, 16'h1000, 16'h1400, 16'h1806,
            16'h1C00, 16'h2000};
        void'($urandom(11));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (tb[i]) begin
            rd(tb[i][15:8], r);
            chk(r, {24'h0, tb[i][7:0]});
        end
        chk(32'({hreadyout, hresp}), 32'h2);
        $display("reset test done");
        a = 3 + $urandom % 18;
        b = 3 + $urandom % 18;
        // mode first: the count sits at 0 then, so it never runs past a compare
        wr(MFT_OFS_MODE_SETUP, 32'h01);
        wr(MFT_OFS_FIRST_CMP, 32'(a));
        wr(MFT_OFS_SECOND_CMP, 32'(b));
        tog(d1);
        tog(d1);
        tog(d2);
        chk(32'(d1 + d2), 32'(a + b + 2));
        chk(32'(d1 == a + 1 || d1 == b + 1), 32'h1);
        $display("pwm test done");
        wr(MFT_OFS_FIRST_CMP, 32'h00FF);
        wr(MFT_OFS_SECOND_CMP, 32'h00FF);
        for (int e = 0; e < 2; e++) begin
            wr(MFT_OFS_MODE_SETUP, e ? 32'h03 : 32'h23);
            k = 1 + $urandom % 15;
            rd(MFT_OFS_COUNTER, c0);
            pins.burst(k, 3 + $urandom % 4);
            repeat (8) @(posedge hclk);
            rd(MFT_OFS_COUNTER, c1);
            chk(c1 - c0, 32'(k));
        end
        $display("event test done");
        for (int n = 0; n < 8; n++) begin
            wr(MFT_OFS_MODE_SETUP, 32'((n << 2) | 2));
            repeat (300) @(posedge hclk);
            k = 100 + $urandom % 400;
            rd(MFT_OFS_COUNTER, c0);
            repeat (k) @(posedge hclk);
            rd(MFT_OFS_COUNTER, c1);
            r = 32'(16'(c1 - c0) - ticks(k, n));
            chk(32'(r <= 1), 32'h1);
        end
        $display("divider test done");
        wr(MFT_OFS_MODE_SETUP, 32'h42);
        wr(MFT_OFS_FLAG_ENABLE, 32'h20);
        rd(MFT_OFS_COUNTER, c0);
        pins.set_pin(0, 1'b1, 12);
        rd(MFT_OFS_COUNTER, c1);
        rd(MFT_OFS_CAPTURE, r);
        chk(32'(r >= c0 && r <= c1), 32'h1);
        pins.set_pin(0, 1'b0, 12);
        wr(MFT_OFS_MODE_SETUP, 32'h02);
        pins.set_pin(1, 1'b1, 12);
        rd(MFT_OFS_FLAG_ENABLE, r);
        chk(r & 32'hE0, 32'h60);
        rd(MFT_OFS_COUNTER, c1);
        pins.set_pin(1, 1'b0, 12);
        rd(MFT_OFS_COUNTER, c2);
        rd(MFT_OFS_SECOND_CMP, r);
        chk(32'(r >= c1 && r <= c2), 32'h1);
        rd(MFT_OFS_FLAG_ENABLE, r);
        chk(r & 32'hE0, 32'hE0);
        chk(32'(timer_irq), 32'h1);
        // write 1 keeps a flag, write 0 clears it
        wr(MFT_OFS_FLAG_ENABLE, 32'hA0);
        rd(MFT_OFS_FLAG_ENABLE, r);
        chk(r & 32'hE0, 32'hA0);
        wr(MFT_OFS_MODE_SETUP, 32'h00);
        #1;
        chk(32'(timer_irq), 32'h0);
        wr(MFT_OFS_FLAG_ENABLE, 32'h20);
        wr(MFT_OFS_MODE_SETUP, 32'h02);
        #1;
        chk(32'(timer_irq), 32'h0);
        $display("capture test done");
        wr(MFT_OFS_FLAG_ENABLE, 32'h01);
        k = 0;
        while (timer_irq !== 1'b1 && k < 70000) begin
            @(posedge hclk);
            k++;
        end
        rd(MFT_OFS_FLAG_ENABLE, r);
        chk(r & 32'h02, 32'h02);
        rd(MFT_OFS_COUNTER, r);
        chk(32'(r < 32'h10), 32'h1);
        $display("wrap test done");
        for (int m = 0; m < 2; m++) begin
            wr(MFT_OFS_IRQ_MASK, m ? 32'h20 : 32'h00);
            rd(MFT_OFS_IRQ_STATUS, r);
            repeat ($urandom % 5) @(posedge hclk);
            rt_wrap <= 1'b1;
            @(posedge hclk);
            rt_wrap <= 1'b0;
            repeat (2) @(posedge hclk);
            chk(32'(irq), 32'(m));
            rd(MFT_OFS_MODE_SETUP, r);
            chk(r & 32'h80, 32'h80);
            rd(MFT_OFS_IRQ_STATUS, r);
            chk(r & 32'h20, 32'h20);
            rd(MFT_OFS_IRQ_STATUS, r);
            chk(r & 32'h20, 32'h00);
            chk(32'(irq), 32'h0);
            wr(MFT_OFS_MODE_SETUP, 32'h02);
            rd(MFT_OFS_MODE_SETUP, r);
            chk(r, 32'h02);
        end
        rd(MFT_OFS_IRQ_MASK, r);
        chk(r, 32'h20);
        $display("interrupt test done");
        close_out();
    end
endmodule : mft_timer_ctrl_test
`default_nettype wire
